/* hw/rffe_sw_pkg.sv */
// constants, carrier types and the routing decode for the switch register bank
package rffe_sw_pkg;

   localparam logic [7:0] ADDR_ROUTE_A = 8'h00;
   localparam logic [7:0] ADDR_ROUTE_B = 8'h01;
   localparam logic [7:0] ADDR_POWER = 8'h1c;
   localparam logic [7:0] ADDR_FAULT_SUM = 8'h24;
   localparam logic [7:0] ADDR_FIXED_PATTERN = 8'h2c;
   localparam logic [7:0] ADDR_EXT_MASK = 8'h2d;
   localparam logic [7:0] ADDR_EXT_FIRE = 8'h2e;

   localparam logic [7:0] FIXED_PATTERN_VALUE = 8'hd2;
   localparam logic [7:0] EXT_MASK_RESET = 8'h00;
   localparam logic [7:0] FAULT_SUM_RESET = 8'h00;
   localparam logic [7:0] ROUTE_RESET = 8'h00;
   localparam logic POWER_RESET = 1'b1;
   localparam int POWER_BIT = 7;

   // extended trigger bit k stands for trigger k+3
   localparam int EXT_BIT_ROUTE_A = 0;
   localparam int EXT_BIT_ROUTE_B = 1;

   localparam int IN1_LSB = 0;
   localparam int IN2_LSB = 3;
   localparam int IN3_LSB = 0;

   localparam int HOST_START_NS = 120;
   localparam int HOST_LOWPWR_US = 10;

   // packed so that bit positions equal the error summary bit positions 6..0
   typedef struct packed {
      logic commandFrameParityFault;
      logic commandLengthFault;
      logic addressFrameParityFault;
      logic dataFrameParityFault;
      logic readBadAddressFault;
      logic writeBadAddressFault;
      logic sharedIdReadFault;
   } faultEvents_t;

   typedef struct packed {
      logic req;
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } linkAccess_t;

   // bit 0 = output 1, bit 1 = output 2, bit 2 = output 3
   typedef struct packed {
      logic [2:0] in3;
      logic [2:0] in2;
      logic [2:0] in1;
   } routeSet_t;

   typedef struct packed {
      logic reqTgl;
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [6:0] faultTgl;
      logic ackSync1;
      logic ackSync2;
      logic ackSeen;
      logic [7:0] rdData;
      logic rdValid;
   } linkState_t;

   typedef struct packed {
      logic reqSync1;
      logic reqSync2;
      logic reqSeen;
      logic [6:0] faultSync1;
      logic [6:0] faultSync2;
      logic [6:0] faultSeen;
      logic [7:0] routeA;
      logic [7:0] routeB;
      logic [7:0] shadowA;
      logic [7:0] shadowB;
      logic [7:0] extMask;
      logic lowPower;
      logic [7:0] errSum;
      logic [7:0] rdData;
      logic ackTgl;
      routeSet_t routes;
   } mainState_t;

   function automatic logic [2:0] decodeRoute(input logic [2:0] code);
      logic [2:0] outs;
      outs = 3'h0;
      case (code)
         3'h0: outs = 3'h0;
         3'h1: outs = 3'h1;
         3'h2: outs = 3'h2;
         3'h3: outs = 3'h4;
         3'h4: outs = 3'h3;
         3'h5: outs = 3'h6;
         3'h6: outs = 3'h5;
         3'h7: outs = 3'h7;
         default: outs = 3'h0;
      endcase
      return outs;
   endfunction

endpackage

/* hw/rffe_switch_error_trigger_regs.sv */
// register bank of the routing switch: error summary, test pattern, extended triggers, routing
`timescale 1ns/1ps
module rffe_switch_error_trigger_regs
   import rffe_sw_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic linkClk,
   input wire linkAccess_t linkAcc,
   input wire faultEvents_t linkFaults,
   output logic [7:0] linkRdData,
   output logic linkRdValid,
   output routeSet_t routeSel,
   output logic lowPowerMode
);

   linkState_t link_ff;
   linkState_t nxt_link;
   mainState_t main_ff;
   mainState_t nxt_main;

   logic take;
   logic [6:0] faultHit;
   logic errRead;
   logic fireA;
   logic fireB;

   // link side: requests and fault events leave as toggles, so a stopped
   // link clock between frames cannot lose or repeat anything
   always_comb begin
      nxt_link = link_ff;
      nxt_link.rdValid = 1'b0;
      if (linkAcc.req) begin
         nxt_link.reqTgl = ~link_ff.reqTgl;
         nxt_link.write = linkAcc.write;
         nxt_link.addr = linkAcc.addr;
         nxt_link.wdata = linkAcc.wdata;
      end
      nxt_link.faultTgl = link_ff.faultTgl ^ linkFaults;
      nxt_link.ackSync1 = main_ff.ackTgl;
      nxt_link.ackSync2 = link_ff.ackSync1;
      nxt_link.ackSeen = link_ff.ackSync2;
      // read data was set together with the ack toggle and is quiet by now
      if (link_ff.ackSync2 != link_ff.ackSeen) begin
         nxt_link.rdData = main_ff.rdData;
         nxt_link.rdValid = 1'b1;
      end
   end

   always_ff @(posedge linkClk or negedge nrst) begin
      if (!nrst) begin
         link_ff <= '0;
      end else begin
         link_ff <= nxt_link;
      end
   end

   assign linkRdData = link_ff.rdData;
   assign linkRdValid = link_ff.rdValid;

   // main side
   always_comb begin
      nxt_main = main_ff;
      nxt_main.reqSync1 = link_ff.reqTgl;
      nxt_main.reqSync2 = main_ff.reqSync1;
      nxt_main.reqSeen = main_ff.reqSync2;
      nxt_main.faultSync1 = link_ff.faultTgl;
      nxt_main.faultSync2 = main_ff.faultSync1;
      nxt_main.faultSeen = main_ff.faultSync2;
      take = main_ff.reqSync2 ^ main_ff.reqSeen;
      faultHit = main_ff.faultSync2 ^ main_ff.faultSeen;
      errRead = take && !link_ff.write && (link_ff.addr == ADDR_FAULT_SUM);
      fireA = 1'b0;
      fireB = 1'b0;

      // events set bits; a clearing read in the same cycle loses to them
      nxt_main.errSum = (errRead ? FAULT_SUM_RESET : main_ff.errSum)
         | {1'b0, faultHit};
      nxt_main.errSum[7] = 1'b0;

      if (take) begin
         nxt_main.ackTgl = ~main_ff.ackTgl;
         nxt_main.rdData = 8'h00;
         if (link_ff.write) begin
            case (link_ff.addr)
               ADDR_ROUTE_A: begin
                  nxt_main.shadowA = link_ff.wdata;
                  if (main_ff.extMask[EXT_BIT_ROUTE_A]) begin
                     nxt_main.routeA = link_ff.wdata;
                  end
               end
               ADDR_ROUTE_B: begin
                  nxt_main.shadowB = link_ff.wdata;
                  if (main_ff.extMask[EXT_BIT_ROUTE_B]) begin
                     nxt_main.routeB = link_ff.wdata;
                  end
               end
               ADDR_POWER: begin
                  nxt_main.lowPower = link_ff.wdata[POWER_BIT];
               end
               ADDR_EXT_MASK: begin
                  nxt_main.extMask = link_ff.wdata;
               end
               ADDR_EXT_FIRE: begin
                  // mask of an earlier byte of the same write is already in place;
                  // the power state is never touched here
                  fireA = link_ff.wdata[EXT_BIT_ROUTE_A]
                     && !main_ff.extMask[EXT_BIT_ROUTE_A];
                  fireB = link_ff.wdata[EXT_BIT_ROUTE_B]
                     && !main_ff.extMask[EXT_BIT_ROUTE_B];
                  if (fireA) begin
                     nxt_main.routeA = main_ff.shadowA;
                  end
                  if (fireB) begin
                     nxt_main.routeB = main_ff.shadowB;
                  end
               end
               default: begin
                  nxt_main.rdData = 8'h00;
               end
            endcase
         end else begin
            case (link_ff.addr)
               ADDR_ROUTE_A: nxt_main.rdData = main_ff.routeA;
               ADDR_ROUTE_B: nxt_main.rdData = main_ff.routeB;
               ADDR_POWER: nxt_main.rdData = {main_ff.lowPower, 7'h00};
               ADDR_FAULT_SUM: nxt_main.rdData = main_ff.errSum;
               ADDR_FIXED_PATTERN: nxt_main.rdData = FIXED_PATTERN_VALUE;
               ADDR_EXT_MASK: nxt_main.rdData = main_ff.extMask;
               ADDR_EXT_FIRE: nxt_main.rdData = 8'h00;
               default: nxt_main.rdData = 8'h00;
            endcase
         end
      end

      // low power isolates every path whatever the routing codes say
      if (nxt_main.lowPower) begin
         nxt_main.routes = '0;
      end else begin
         nxt_main.routes.in1 = decodeRoute(nxt_main.routeA[IN1_LSB +: 3]);
         nxt_main.routes.in2 = decodeRoute(nxt_main.routeA[IN2_LSB +: 3]);
         nxt_main.routes.in3 = decodeRoute(nxt_main.routeB[IN3_LSB +: 3]);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         main_ff <= '0;
         main_ff.routeA <= ROUTE_RESET;
         main_ff.routeB <= ROUTE_RESET;
         main_ff.shadowA <= ROUTE_RESET;
         main_ff.shadowB <= ROUTE_RESET;
         main_ff.extMask <= EXT_MASK_RESET;
         main_ff.errSum <= FAULT_SUM_RESET;
         main_ff.lowPower <= POWER_RESET;
      end else begin
         main_ff <= nxt_main;
      end
   end

   assign routeSel = main_ff.routes;
   assign lowPowerMode = main_ff.lowPower;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   logic wrTake;
   logic rdTake;
   assign wrTake = take && link_ff.write;
   assign rdTake = take && !link_ff.write;

   a_err_cmdpar: assert property (faultHit[6] |=> main_ff.errSum[6])
      else $error("command parity fault not recorded");
   a_err_cmdlen: assert property (faultHit[5] |=> main_ff.errSum[5])
      else $error("command length fault not recorded");
   a_err_addrpar: assert property (faultHit[4] |=> main_ff.errSum[4])
      else $error("address parity fault not recorded");
   a_err_datapar: assert property (faultHit[3] |=> main_ff.errSum[3])
      else $error("data parity fault not recorded");
   a_err_rdaddr: assert property (faultHit[2] |=> main_ff.errSum[2])
      else $error("read bad address fault not recorded");
   a_err_wraddr: assert property (faultHit[1] |=> main_ff.errSum[1])
      else $error("write bad address fault not recorded");
   a_err_sharedid: assert property (faultHit[0] |=> main_ff.errSum[0])
      else $error("shared id read fault not recorded");
   a_spare_zero: assert property (main_ff.errSum[7] == 1'b0)
      else $error("error summary spare bit set");
   a_err_rdclear: assert property (errRead && faultHit == 7'h00 |=>
      main_ff.errSum == 8'h00 && main_ff.rdData == $past(main_ff.errSum))
      else $error("error summary read did not return then clear");
   a_err_sticky: assert property (main_ff.errSum[6] && !errRead |=>
      main_ff.errSum[6])
      else $error("error bit dropped without a read");
   a_patt_read: assert property (rdTake && link_ff.addr == ADDR_FIXED_PATTERN |=>
      main_ff.rdData == FIXED_PATTERN_VALUE)
      else $error("test pattern read wrong");
   a_mask_write: assert property (wrTake && link_ff.addr == ADDR_EXT_MASK |=>
      main_ff.extMask == $past(link_ff.wdata))
      else $error("extended mask not written");
   a_trig_load: assert property (wrTake && link_ff.addr == ADDR_EXT_FIRE
      && link_ff.wdata[0] && !main_ff.extMask[0] |=>
      main_ff.routeA == $past(main_ff.shadowA))
      else $error("unmasked trigger did not load shadow");
   a_trig_masked: assert property (wrTake && link_ff.addr == ADDR_EXT_FIRE
      && main_ff.extMask[0] |=> $stable(main_ff.routeA))
      else $error("masked trigger changed register");
   a_trig_power: assert property (wrTake && link_ff.addr == ADDR_EXT_FIRE |=>
      $stable(main_ff.lowPower))
      else $error("extended trigger changed power state");
   a_trig_rdzero: assert property (rdTake && link_ff.addr == ADDR_EXT_FIRE |=>
      main_ff.rdData == 8'h00)
      else $error("extended trigger read not zero");
   a_shadow_write: assert property (wrTake && link_ff.addr == ADDR_ROUTE_A
      && !main_ff.extMask[0] |=> $stable(main_ff.routeA)
      && main_ff.shadowA == $past(link_ff.wdata))
      else $error("enabled trigger write reached active register");
   a_route_one: assert property (!main_ff.lowPower |->
      main_ff.routes.in1 == decodeRoute(main_ff.routeA[2:0]))
      else $error("input one routing wrong");
   a_route_two: assert property (!main_ff.lowPower |->
      main_ff.routes.in2 == decodeRoute(main_ff.routeA[5:3]))
      else $error("input two routing wrong");
   a_route_three: assert property (!main_ff.lowPower |->
      main_ff.routes.in3 == decodeRoute(main_ff.routeB[2:0]))
      else $error("input three routing wrong");
   a_power_iso: assert property (main_ff.lowPower |-> main_ff.routes == '0)
      else $error("path open in low power");

   // every remaining fault bit is sticky until a read
   a_sticky_five: assert property (main_ff.errSum[5] && !errRead |=>
      main_ff.errSum[5])
      else $error("length fault bit dropped without a read");
   a_sticky_four: assert property (main_ff.errSum[4] && !errRead |=>
      main_ff.errSum[4])
      else $error("address parity bit dropped without a read");
   a_sticky_three: assert property (main_ff.errSum[3] && !errRead |=>
      main_ff.errSum[3])
      else $error("data parity bit dropped without a read");
   a_sticky_two: assert property (main_ff.errSum[2] && !errRead |=>
      main_ff.errSum[2])
      else $error("read address bit dropped without a read");
   a_sticky_one: assert property (main_ff.errSum[1] && !errRead |=>
      main_ff.errSum[1])
      else $error("write address bit dropped without a read");
   a_sticky_zero: assert property (main_ff.errSum[0] && !errRead |=>
      main_ff.errSum[0])
      else $error("shared id bit dropped without a read");

   // a fault bit only rises one cycle after its event was seen
   a_rise_six: assert property ($rose(main_ff.errSum[6]) |->
      $past(faultHit[6]))
      else $error("command parity bit set without event");
   a_rise_five: assert property ($rose(main_ff.errSum[5]) |->
      $past(faultHit[5]))
      else $error("command length bit set without event");
   a_rise_four: assert property ($rose(main_ff.errSum[4]) |->
      $past(faultHit[4]))
      else $error("address parity bit set without event");
   a_rise_three: assert property ($rose(main_ff.errSum[3]) |->
      $past(faultHit[3]))
      else $error("data parity bit set without event");
   a_rise_two: assert property ($rose(main_ff.errSum[2]) |->
      $past(faultHit[2]))
      else $error("read address bit set without event");
   a_rise_one: assert property ($rose(main_ff.errSum[1]) |->
      $past(faultHit[1]))
      else $error("write address bit set without event");
   a_rise_zero: assert property ($rose(main_ff.errSum[0]) |->
      $past(faultHit[0]))
      else $error("shared id bit set without event");

   // second trigger path, routing register one
   a_trigb_load: assert property (wrTake && link_ff.addr == ADDR_EXT_FIRE
      && link_ff.wdata[EXT_BIT_ROUTE_B] && !main_ff.extMask[EXT_BIT_ROUTE_B] |=>
      main_ff.routeB == $past(main_ff.shadowB))
      else $error("unmasked second trigger did not load shadow");
   a_trigb_masked: assert property (wrTake && link_ff.addr == ADDR_EXT_FIRE
      && main_ff.extMask[EXT_BIT_ROUTE_B] |=> $stable(main_ff.routeB))
      else $error("masked second trigger changed register");
   a_shadowb_write: assert property (wrTake && link_ff.addr == ADDR_ROUTE_B
      && !main_ff.extMask[EXT_BIT_ROUTE_B] |=> $stable(main_ff.routeB)
      && main_ff.shadowB == $past(link_ff.wdata))
      else $error("enabled trigger write reached second register");
   a_direct_a: assert property (wrTake && link_ff.addr == ADDR_ROUTE_A
      && main_ff.extMask[EXT_BIT_ROUTE_A] |=> main_ff.routeA == $past(link_ff.wdata))
      else $error("disabled trigger write missed first register");
   a_direct_b: assert property (wrTake && link_ff.addr == ADDR_ROUTE_B
      && main_ff.extMask[EXT_BIT_ROUTE_B] |=> main_ff.routeB == $past(link_ff.wdata))
      else $error("disabled trigger write missed second register");
   a_trig_shadowkeep: assert property (wrTake && link_ff.addr == ADDR_EXT_FIRE |=>
      $stable(main_ff.shadowA) && $stable(main_ff.shadowB))
      else $error("trigger disturbed shadow contents");
   a_trig_maskkeep: assert property (wrTake && link_ff.addr == ADDR_EXT_FIRE |=>
      $stable(main_ff.extMask))
      else $error("trigger write changed the mask");

   // registers move only when a write reaches them
   a_power_write: assert property (wrTake && link_ff.addr == ADDR_POWER |=>
      main_ff.lowPower == $past(link_ff.wdata[POWER_BIT]))
      else $error("power bit not written");
   a_power_hold: assert property (!(wrTake && link_ff.addr == ADDR_POWER) |=>
      $stable(main_ff.lowPower))
      else $error("power state moved without a power write");
   a_mask_hold: assert property (!(wrTake && link_ff.addr == ADDR_EXT_MASK) |=>
      $stable(main_ff.extMask))
      else $error("mask moved without a mask write");
   a_route_hold: assert property (!take |=>
      $stable(main_ff.routeA) && $stable(main_ff.routeB))
      else $error("routing register moved without an access");
   a_shadow_hold: assert property (!wrTake |=>
      $stable(main_ff.shadowA) && $stable(main_ff.shadowB))
      else $error("shadow moved without a write");
   a_mask_read: assert property (rdTake && link_ff.addr == ADDR_EXT_MASK |=>
      main_ff.rdData == $past(main_ff.extMask))
      else $error("mask read wrong");
   a_reada_value: assert property (rdTake && link_ff.addr == ADDR_ROUTE_A |=>
      main_ff.rdData == $past(main_ff.routeA))
      else $error("first routing read wrong");
   a_readb_value: assert property (rdTake && link_ff.addr == ADDR_ROUTE_B |=>
      main_ff.rdData == $past(main_ff.routeB))
      else $error("second routing read wrong");
   a_ack_toggle: assert property (take |=>
      main_ff.ackTgl != $past(main_ff.ackTgl))
      else $error("access not acknowledged");
   a_link_pulse: assert property (@(posedge linkClk) disable iff (!nrst)
      linkRdValid |=> !linkRdValid)
      else $error("answer strobe longer than one link cycle");

   // input one against the routing table, code by code
   a_in1_code0: assert property (!main_ff.lowPower && main_ff.routeA[2:0] == 3'h0 |->
      main_ff.routes.in1 == 3'h0)
      else $error("code 0 routing wrong");
   a_in1_code1: assert property (!main_ff.lowPower && main_ff.routeA[2:0] == 3'h1 |->
      main_ff.routes.in1 == 3'h1)
      else $error("code 1 routing wrong");
   a_in1_code2: assert property (!main_ff.lowPower && main_ff.routeA[2:0] == 3'h2 |->
      main_ff.routes.in1 == 3'h2)
      else $error("code 2 routing wrong");
   a_in1_code3: assert property (!main_ff.lowPower && main_ff.routeA[2:0] == 3'h3 |->
      main_ff.routes.in1 == 3'h4)
      else $error("code 3 routing wrong");
   a_in1_code4: assert property (!main_ff.lowPower && main_ff.routeA[2:0] == 3'h4 |->
      main_ff.routes.in1 == 3'h3)
      else $error("code 4 routing wrong");
   a_in1_code5: assert property (!main_ff.lowPower && main_ff.routeA[2:0] == 3'h5 |->
      main_ff.routes.in1 == 3'h6)
      else $error("code 5 routing wrong");
   a_in1_code6: assert property (!main_ff.lowPower && main_ff.routeA[2:0] == 3'h6 |->
      main_ff.routes.in1 == 3'h5)
      else $error("code 6 routing wrong");
   a_in1_code7: assert property (!main_ff.lowPower && main_ff.routeA[2:0] == 3'h7 |->
      main_ff.routes.in1 == 3'h7)
      else $error("code 7 routing wrong");

   c_trig_fire: cover property (wrTake && link_ff.addr == ADDR_EXT_FIRE && fireA);
   c_err_read: cover property (errRead && main_ff.errSum != 8'h00);
   c_shadow: cover property (wrTake && link_ff.addr == ADDR_ROUTE_A && !main_ff.extMask[0]);
   c_wake: cover property (main_ff.lowPower ##1 !main_ff.lowPower);
   c_trig_masked: cover property (wrTake && link_ff.addr == ADDR_EXT_FIRE
      && link_ff.wdata[EXT_BIT_ROUTE_A] && main_ff.extMask[EXT_BIT_ROUTE_A]);

endmodule

/* verification/bus_master_model.sv */
// bus master model: register accesses and fault pulses on the link side
`timescale 1ns/1ps
module bus_master_model
   import rffe_sw_pkg::*;
(
   output logic linkClk,
   output linkAccess_t linkAcc,
   output faultEvents_t linkFaults,
   input wire logic [7:0] linkRdData,
   input wire logic linkRdValid
);
   initial begin
      linkClk = 1'b0;
      linkAcc = '0;
      linkFaults = '0;
   end

   // the link clock only runs inside a frame, 6 ns period
   task automatic tick();
      #3 linkClk = 1'b1;
      #3 linkClk = 1'b0;
   endtask

   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
         output logic [7:0] rd, output bit ok);
      if ($time < HOST_START_NS) #(HOST_START_NS - $time);
      // let the released lines settle before the next request goes up
      #3;
      ok = 1'b0;
      rd = 8'h00;
      linkAcc = '{req: 1'b1, write: wr, addr: a, wdata: d};
      tick();
      linkAcc.req = 1'b0;
      // keep clocking until the answer, sampled just ahead of each rising edge
      for (int n = 0; n < 40 && !ok; n++) begin
         #3;
         ok = (linkRdValid === 1'b1);
         rd = linkRdData;
         linkClk = 1'b1;
         #3 linkClk = 1'b0;
      end
      // released lines must not keep showing the last value
      linkAcc.write = ~wr;
      linkAcc.addr = ~a;
      linkAcc.wdata = ~d;
   endtask

   task automatic fault(input faultEvents_t f);
      linkFaults = f;
      tick();
      linkFaults = '0;
      // the frame clock runs on until the main side has seen the event,
      // so that a second event on the same bit is not folded into the first
      repeat (16) tick();
   endtask
endmodule

/* verification/rffe_switch_error_trigger_regs_bench.sv */
// self-checking bench for the switch register bank
`timescale 1ns/1ps
module rffe_switch_error_trigger_regs_bench import rffe_sw_pkg::*;;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic linkClk;
   linkAccess_t linkAcc;
   faultEvents_t linkFaults;
   logic [7:0] linkRdData;
   logic linkRdValid;
   routeSet_t routeSel;
   logic lowPowerMode;
   int fail_count = 0;
   int n_compared = 0;
   logic [2:0] outsOf [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3, 3'h6, 3'h5, 3'h7};

   always #10 mclk = ~mclk;

   rffe_switch_error_trigger_regs rffe_switch_error_trigger_regs_inst (
      .mclk(mclk),
      .nrst(nrst),
      .linkClk(linkClk),
      .linkAcc(linkAcc),
      .linkFaults(linkFaults),
      .linkRdData(linkRdData),
      .linkRdValid(linkRdValid),
      .routeSel(routeSel),
      .lowPowerMode(lowPowerMode)
   );

   bus_master_model bus_master_model_inst (
      .linkClk(linkClk),
      .linkAcc(linkAcc),
      .linkFaults(linkFaults),
      .linkRdData(linkRdData),
      .linkRdValid(linkRdValid)
   );

   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [8:0] e, input logic [8:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
         output logic [7:0] rd);
      bit ok;
      bus_master_model_inst.access(wr, a, d, rd, ok);
      if (!ok) begin
         fail_count++;
         $display("Error answer at %h expected 1 seen 0", a);
         close_out();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] rd;
      xfer(1'b1, a, d, rd);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] rd;
      xfer(1'b0, a, 8'h00, rd);
      check($sformatf("read %h", a), {1'b0, e}, {1'b0, rd});
   endtask

   initial begin
      repeat (2) @(negedge mclk);
      nrst = 1'b1;
      check("routeSel", 9'h000, routeSel);
      check("lowPowerMode", 9'h001, {8'h00, lowPowerMode});
      rdchk(ADDR_FAULT_SUM, 8'h00);
      rdchk(ADDR_EXT_MASK, 8'h00);
      wr(ADDR_FIXED_PATTERN, 8'h55);
      rdchk(ADDR_FIXED_PATTERN, 8'hd2);
      wr(ADDR_EXT_FIRE, 8'h00);
      rdchk(ADDR_EXT_FIRE, 8'h00);
      $display("test reset and fixed values done");

      // a repeated fault on the same bit must not toggle it back
      for (int i = 0; i < 7; i++) begin
         bus_master_model_inst.fault(faultEvents_t'(7'h01 << i));
         bus_master_model_inst.fault(faultEvents_t'(7'h01 << i));
         repeat (5) @(negedge mclk);
         rdchk(ADDR_FAULT_SUM, 8'h01 << i);
         rdchk(ADDR_FAULT_SUM, 8'h00);
      end
      bus_master_model_inst.fault(faultEvents_t'(7'h7f));
      repeat (5) @(negedge mclk);
      rdchk(ADDR_FAULT_SUM, 8'h7f);
      rdchk(ADDR_FAULT_SUM, 8'h00);
      $display("test error summary done");

      #(HOST_LOWPWR_US * 1000);
      @(negedge mclk);
      wr(ADDR_POWER, 8'h00);
      repeat (2) @(negedge mclk);
      check("lowPowerMode", 9'h000, {8'h00, lowPowerMode});
      wr(ADDR_ROUTE_A, 8'h0a);
      wr(ADDR_ROUTE_B, 8'h05);
      rdchk(ADDR_ROUTE_A, 8'h00);
      rdchk(ADDR_ROUTE_B, 8'h00);
      check("routeSel", 9'h000, routeSel);
      wr(ADDR_EXT_MASK, 8'h01);
      wr(ADDR_EXT_FIRE, 8'h01);
      repeat (3) @(negedge mclk);
      check("routeSel", 9'h000, routeSel);
      wr(ADDR_EXT_MASK, 8'h00);
      wr(ADDR_EXT_FIRE, 8'h03);
      repeat (3) @(negedge mclk);
      check("routeSel", {3'h6, 3'h1, 3'h2}, routeSel);
      check("lowPowerMode", 9'h000, {8'h00, lowPowerMode});
      $display("test extended trigger done");

      // masked triggers let writes reach the active registers directly
      wr(ADDR_EXT_MASK, 8'h03);
      rdchk(ADDR_EXT_MASK, 8'h03);
      for (int k = 0; k < 8; k++) begin
         wr(ADDR_ROUTE_A, {2'b00, 3'(7 - k), 3'(k)});
         wr(ADDR_ROUTE_B, {5'b00000, 3'(k ^ 3)});
         repeat (2) @(negedge mclk);
         check("routeSel", {outsOf[k ^ 3], outsOf[7 - k], outsOf[k]},
            routeSel);
      end
      wr(ADDR_POWER, 8'h80);
      repeat (2) @(negedge mclk);
      check("lowPowerMode", 9'h001, {8'h00, lowPowerMode});
      check("routeSel", 9'h000, routeSel);
      $display("test routing decode and power done");
      close_out();
   end
endmodule
